// ### include/se_pkg.sv
// package for the serial eeprom host engine
// assumes a 200 MHz system clock and one eeprom on a two-wire bus
package se_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	// device address byte fields
	localparam logic [3:0] TYPE_ARRAY = 4'hA;
	localparam logic [3:0] TYPE_SERIAL = 4'hB;
	localparam logic RW_WRITE = 1'b0;
	localparam logic RW_READ = 1'b1;
	localparam logic REGION_ARRAY = 1'b0;
	// word address layout
	localparam int ADDR_W = 12;
	localparam int PAGE_BITS = 5;
	localparam logic [5:0] PAGE_BYTES = 6'h20;
	localparam logic [3:0] HI_PAD = 4'h0;
	// byte engine
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [7:0] RX_IDLE = 8'hFF;
	localparam int LEN_W = 6;

	typedef enum logic [1:0] {OP_WRITE, OP_READ_CUR, OP_READ_RAND, OP_POLL} se_op_t;
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BIT, ST_WAIT, ST_STOP} se_state_t;
	typedef enum logic [2:0] {PH_DEVW, PH_HI, PH_LO, PH_WDATA, PH_DEVR, PH_RDATA} se_phase_t;

	typedef struct packed {
		se_op_t op;
		logic region;
		logic [2:0] straps;
		logic [ADDR_W-1:0] addr;
		logic [LEN_W-1:0] len;
	} se_cmd_t;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} se_rd_t;
endpackage

// ### rtl/se_sync.sv
// two-flop synchroniser for pin inputs
// assumes the inputs are asynchronous levels
`timescale 1ns/100ps
module se_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	always_comb begin
		next_meta = d_i;
		next_q = meta;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta <= '1;
			q_o <= '1;
		end else begin
			meta <= next_meta;
			q_o <= next_q;
		end
	end
endmodule

// ### rtl/se_host.sv
// host engine driving a two-wire serial eeprom: writes, reads, ack polling
// assumes one command at a time and an external pull-up on sda
//
// Overview of operation
// - write sends start, write address, word address, data
// - target byte chosen by 12-bit word address
// - stop after write data starts programming
// - page write sends up to 31 more bytes
// - never send more bytes than page holds
// - poll with start and write address until ack, at most POLL_MAX tries
// - read address byte has direction bit one
// - shared pointer; dummy write when switching region (code refuses a current read in another region with err_o)
// - read ends with nack in ninth clock
// - random read: dummy write then repeated start read
// - address byte: type code, straps, direction
// - first word byte holds bits 11..8 low
`timescale 1ns/100ps
module se_host #(
	parameter int QUARTER = se_pkg::QUARTER_CYC,
	parameter int POLL_MAX = 200
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// command
	input se_pkg::se_cmd_t cmd_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	// write data
	input wire logic [7:0] wr_data_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	// read data
	output se_pkg::se_rd_t rd_o,
	output logic rd_valid_o,
	// status
	output logic busy_o,
	output logic done_o,
	output logic err_o,
	// bus pins
	output logic scl_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o
);
	localparam int DIV_W = $clog2(QUARTER + 1);
	localparam int POLL_W = $clog2(POLL_MAX + 1);

	// device address byte from region, straps and direction
	function automatic logic [7:0] dev_byte(input logic region, input logic [2:0] straps,
			input logic rw);
		dev_byte = {(region == se_pkg::REGION_ARRAY) ? se_pkg::TYPE_ARRAY : se_pkg::TYPE_SERIAL,
			straps, rw};
	endfunction

	logic sda_s;

	se_sync #(
		.W(1)
	) u_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.d_i(sda_i),
		.q_o(sda_s)
	);

	// quarter-period tick of scl
	logic [DIV_W-1:0] div;
	logic [DIV_W-1:0] next_div;
	logic tick;

	always_comb begin
		tick = (div == '0);
		next_div = tick ? DIV_W'(QUARTER - 1) : div - 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			div <= '0;
		end else begin
			div <= next_div;
		end
	end

	// transaction engine
	se_pkg::se_state_t state;
	se_pkg::se_state_t next_state;
	se_pkg::se_phase_t phase;
	se_pkg::se_phase_t next_phase;
	se_pkg::se_cmd_t cmd;
	se_pkg::se_cmd_t next_cmd;
	logic [1:0] q;
	logic [1:0] next_q;
	logic [3:0] bitn;
	logic [3:0] next_bitn;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [se_pkg::LEN_W-1:0] cnt;
	logic [se_pkg::LEN_W-1:0] next_cnt;
	logic [se_pkg::LEN_W-1:0] room;
	logic [POLL_W-1:0] poll_cnt;
	logic [POLL_W-1:0] next_poll_cnt;
	logic ack_bad;
	logic next_ack_bad;
	logic err_pend;
	logic next_err_pend;
	logic last_region;
	logic next_last_region;
	logic drive_bit;
	logic next_cmd_ready;
	logic next_wr_ready;
	se_pkg::se_rd_t next_rd;
	logic next_rd_valid;
	logic next_busy;
	logic next_done;
	logic next_err;
	logic next_scl;
	logic next_sda_oe_n;

	always_comb begin
		next_state = state;
		next_phase = phase;
		next_cmd = cmd;
		next_q = q;
		next_bitn = bitn;
		next_shreg = shreg;
		next_cnt = cnt;
		next_poll_cnt = poll_cnt;
		next_ack_bad = ack_bad;
		next_err_pend = err_pend;
		next_last_region = last_region;
		next_cmd_ready = cmd_ready_o;
		next_wr_ready = wr_ready_o;
		next_rd = rd_o;
		next_rd_valid = 1'b0;
		next_busy = busy_o;
		next_done = 1'b0;
		next_err = 1'b0;
		next_scl = scl_o;
		next_sda_oe_n = sda_oe_n_o;
		room = se_pkg::PAGE_BYTES - {1'b0, cmd_i.addr[se_pkg::PAGE_BITS-1:0]};
		// receiver drives ack, or nack on the last read byte
		if (bitn == se_pkg::ACK_BIT) begin
			drive_bit = (phase == se_pkg::PH_RDATA) ? (cnt == 6'h01) : 1'b1;
		end else begin
			drive_bit = (phase == se_pkg::PH_RDATA) ? 1'b1 : shreg[7];
		end
		case (state)
			se_pkg::ST_IDLE: begin
				if (cmd_valid_i && cmd_ready_o) begin
					next_cmd = cmd_i;
					next_err_pend = 1'b0;
					next_poll_cnt = '0;
					// current read in another region needs a dummy write first
					if ((cmd_i.len == '0 && cmd_i.op != se_pkg::OP_POLL) ||
							(cmd_i.op == se_pkg::OP_READ_CUR &&
							cmd_i.region != last_region)) begin
						next_done = 1'b1;
						next_err = 1'b1;
					end else begin
						next_cmd_ready = 1'b0;
						next_busy = 1'b1;
						next_state = se_pkg::ST_START;
						next_q = 2'h0;
						next_cnt = cmd_i.len;
						if (cmd_i.op == se_pkg::OP_WRITE && cmd_i.len > room) begin
							next_cnt = room;
						end
						next_phase = (cmd_i.op == se_pkg::OP_READ_CUR) ?
							se_pkg::PH_DEVR : se_pkg::PH_DEVW;
					end
				end
			end
			se_pkg::ST_START: begin
				if (tick) begin
					next_q = q + 2'h1;
					case (q)
						2'h0: begin
							next_scl = 1'b0;
							next_sda_oe_n = 1'b1;
						end
						2'h1: next_scl = 1'b1;
						2'h2: next_sda_oe_n = 1'b0;
						default: begin
							next_scl = 1'b0;
							next_state = se_pkg::ST_BIT;
							next_bitn = 4'h0;
							if (phase == se_pkg::PH_DEVR) begin
								next_shreg = dev_byte(cmd.region, cmd.straps,
									se_pkg::RW_READ);
							end else begin
								next_shreg = dev_byte(cmd.region, cmd.straps,
									se_pkg::RW_WRITE);
							end
						end
					endcase
				end
			end
			se_pkg::ST_BIT: begin
				if (tick) begin
					next_q = q + 2'h1;
					case (q)
						2'h0: begin
							next_scl = 1'b0;
							next_sda_oe_n = drive_bit;
						end
						2'h1: next_scl = 1'b1;
						2'h2: begin
							if (bitn == se_pkg::ACK_BIT) begin
								next_ack_bad = sda_s;
							end else begin
								next_shreg = {shreg[6:0], sda_s};
							end
						end
						default: begin
							next_scl = 1'b0;
							next_bitn = bitn + 4'h1;
							if (bitn == se_pkg::ACK_BIT) begin
								next_bitn = 4'h0;
								next_sda_oe_n = 1'b1;
								case (phase)
									se_pkg::PH_DEVW: begin
										if (ack_bad && cmd.op == se_pkg::OP_POLL &&
												poll_cnt != POLL_W'(POLL_MAX - 1)) begin
											next_poll_cnt = poll_cnt + 1'b1;
											next_state = se_pkg::ST_START;
										end else if (ack_bad) begin
											next_err_pend = 1'b1;
											next_state = se_pkg::ST_STOP;
										end else if (cmd.op == se_pkg::OP_POLL) begin
											next_state = se_pkg::ST_STOP;
										end else begin
											next_phase = se_pkg::PH_HI;
											next_shreg = {se_pkg::HI_PAD, cmd.addr[11:8]};
										end
									end
									se_pkg::PH_HI: begin
										if (ack_bad) begin
											next_err_pend = 1'b1;
											next_state = se_pkg::ST_STOP;
										end else begin
											next_phase = se_pkg::PH_LO;
											next_shreg = cmd.addr[7:0];
										end
									end
									se_pkg::PH_LO: begin
										if (ack_bad) begin
											next_err_pend = 1'b1;
											next_state = se_pkg::ST_STOP;
										end else begin
											next_last_region = cmd.region;
											if (cmd.op == se_pkg::OP_WRITE) begin
												next_phase = se_pkg::PH_WDATA;
												next_state = se_pkg::ST_WAIT;
												next_wr_ready = 1'b1;
											end else begin
												next_phase = se_pkg::PH_DEVR;
												next_state = se_pkg::ST_START;
											end
										end
									end
									se_pkg::PH_WDATA: begin
										next_cnt = cnt - 1'b1;
										if (ack_bad) begin
											next_err_pend = 1'b1;
											next_state = se_pkg::ST_STOP;
										end else if (cnt == 6'h01) begin
											next_state = se_pkg::ST_STOP;
										end else begin
											next_state = se_pkg::ST_WAIT;
											next_wr_ready = 1'b1;
										end
									end
									se_pkg::PH_DEVR: begin
										if (ack_bad) begin
											next_err_pend = 1'b1;
											next_state = se_pkg::ST_STOP;
										end else begin
											next_last_region = cmd.region;
											next_phase = se_pkg::PH_RDATA;
											next_shreg = se_pkg::RX_IDLE;
										end
									end
									default: begin
										next_rd = {shreg, cnt == 6'h01};
										next_rd_valid = 1'b1;
										next_cnt = cnt - 1'b1;
										next_shreg = se_pkg::RX_IDLE;
										if (cnt == 6'h01) begin
											next_state = se_pkg::ST_STOP;
										end
									end
								endcase
							end
						end
					endcase
				end
			end
			se_pkg::ST_WAIT: begin
				if (wr_ready_o && wr_valid_i) begin
					next_wr_ready = 1'b0;
					next_shreg = wr_data_i;
					next_bitn = 4'h0;
					next_q = 2'h0;
					next_state = se_pkg::ST_BIT;
				end
			end
			se_pkg::ST_STOP: begin
				if (tick) begin
					next_q = q + 2'h1;
					case (q)
						2'h0: begin
							next_scl = 1'b0;
							next_sda_oe_n = 1'b0;
						end
						2'h1: next_scl = 1'b1;
						2'h2: next_sda_oe_n = 1'b1;
						default: begin
							next_state = se_pkg::ST_IDLE;
							next_done = 1'b1;
							next_err = err_pend;
							next_busy = 1'b0;
							next_cmd_ready = 1'b1;
						end
					endcase
				end
			end
			default: next_state = se_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state <= se_pkg::ST_IDLE;
			phase <= se_pkg::PH_DEVW;
			cmd <= '0;
			q <= 2'h0;
			bitn <= 4'h0;
			shreg <= 8'hFF;
			cnt <= '0;
			poll_cnt <= '0;
			ack_bad <= 1'b0;
			err_pend <= 1'b0;
			last_region <= se_pkg::REGION_ARRAY;
			cmd_ready_o <= 1'b1;
			wr_ready_o <= 1'b0;
			rd_o <= '0;
			rd_valid_o <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			err_o <= 1'b0;
			scl_o <= 1'b1;
			sda_o <= 1'b0;
			sda_oe_n_o <= 1'b1;
		end else begin
			state <= next_state;
			phase <= next_phase;
			cmd <= next_cmd;
			q <= next_q;
			bitn <= next_bitn;
			shreg <= next_shreg;
			cnt <= next_cnt;
			poll_cnt <= next_poll_cnt;
			ack_bad <= next_ack_bad;
			err_pend <= next_err_pend;
			last_region <= next_last_region;
			cmd_ready_o <= next_cmd_ready;
			wr_ready_o <= next_wr_ready;
			rd_o <= next_rd;
			rd_valid_o <= next_rd_valid;
			busy_o <= next_busy;
			done_o <= next_done;
			err_o <= next_err;
			scl_o <= next_scl;
			sda_o <= 1'b0;
			sda_oe_n_o <= next_sda_oe_n;
		end
	end
endmodule

// ### test/se_eeprom_model.sv
// behavioural eeprom device at the two-wire pins, one shared pointer
// assumes a pull-up on sda: the wire is high unless some party pulls it low
`timescale 1ns/100ps
module se_eeprom_model #(
	parameter logic [2:0] STRAPS = 3'h5,
	parameter int PROG = 300
) (
	// clock and pins
	input wire logic clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic protect_i,
	output logic sda_low_o
);
	logic [7:0] mem [4096];
	logic [7:0] sh;
	logic [11:0] ptr = 12'h000;
	logic [19:0] pend [$];
	logic mack;
	int bits = 0;
	int ph = 5;
	int busy = 0;
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
		sda_low_o = 1'b0;
	end
	// programming time in clocks
	always @(posedge clk_i) if (busy > 0) busy = busy - 1;
	// start: deaf while programming
	always @(negedge sda_i) if (scl_i === 1'b1) begin
		bits = 0;
		ph = busy > 0 ? 5 : 0;
		pend.delete();
	end
	// stop: protect sampled here only
	always @(posedge sda_i) if (scl_i === 1'b1) begin
		if (pend.size() > 0 && protect_i !== 1'b1) begin
			busy = PROG;
			foreach (pend[i]) mem[pend[i][19:8]] = pend[i][7:0];
		end
		pend.delete();
		ph = 5;
	end
	always @(posedge scl_i) if (ph != 5) begin
		bits++;
		if (bits < 9) sh = {sh[6:0], sda_i};
		else if (ph == 4) mack = !sda_i;
	end
	always @(negedge scl_i) if (ph != 5) begin
		sda_low_o = 1'b0;
		if (bits == 8 && ph == 0) begin
			sda_low_o = sh[7:5] == 3'h5 && sh[3:1] == STRAPS;
			ph = !sda_low_o ? 5 : sh[0] ? 4 : 1;
			mack = 1'b1;
		end else if (bits == 8 && ph != 4) begin
			sda_low_o = 1'b1;
			if (ph == 3) pend.push_back({ptr, sh});
			if (ph == 3) ptr[4:0] = ptr[4:0] + 5'h01;
			if (ph == 2) ptr[7:0] = sh;
			if (ph == 1) ptr[11:8] = sh[3:0];
			if (ph < 3) ph++;
		end
		if (bits == 9) begin
			bits = 0;
			if (ph == 4 && mack) begin
				sh = mem[ptr];
				ptr = ptr + 12'h001;
			end else if (ph == 4) ph = 5;
		end
		if (ph == 4 && bits < 8) sda_low_o = !sh[7];
	end
endmodule

// ### test/se_host_checker.sv
// port checker for se_host
// assumes it is bound to every se_host instance
`timescale 1ns/100ps
module se_host_checker (
	// watched ports
	input wire logic clk_i,
	input wire logic reset_i,
	input se_pkg::se_cmd_t cmd_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_ready_o,
	input wire logic wr_valid_i,
	input wire logic wr_ready_o,
	input se_pkg::se_rd_t rd_o,
	input wire logic rd_valid_o,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic err_o,
	input wire logic scl_o,
	input wire logic sda_oe_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	property p_refuse;
		cmd_valid_i && cmd_ready_o && cmd_i.len == 6'h00 && cmd_i.op != se_pkg::OP_POLL
			|=> done_o && err_o;
	endproperty
	a_refuse: assert property (p_refuse) else $error("empty length taken");
	property p_err_done; err_o |-> done_o; endproperty
	a_err_done: assert property (p_err_done) else $error("error without done");
	property p_idle; !busy_o |-> scl_o && sda_oe_n_o; endproperty
	a_idle: assert property (p_idle) else $error("bus not idle");
	property p_wr_wait; wr_ready_o && !wr_valid_i |-> !scl_o; endproperty
	a_wr_wait: assert property (p_wr_wait) else $error("clock runs without data");
	property p_wr_take; wr_ready_o && wr_valid_i |=> !wr_ready_o; endproperty
	a_wr_take: assert property (p_wr_take) else $error("extra byte asked");
	property p_stop_done; scl_o && $past(scl_o) && $rose(sda_oe_n_o) |-> ##[1:300] done_o;
	endproperty
	a_stop_done: assert property (p_stop_done) else $error("stop without done");
	property p_rd_end; rd_valid_o && rd_o.last |-> ##[1:1000] done_o; endproperty
	a_rd_end: assert property (p_rd_end) else $error("read not ended");
	property p_one_cmd; $rose(busy_o) |-> !cmd_ready_o; endproperty
	a_one_cmd: assert property (p_one_cmd) else $error("ready while busy");
	c_ok: cover property (done_o && !err_o);
	c_err: cover property (done_o && err_o);
	c_last: cover property (rd_valid_o && rd_o.last);
endmodule
bind se_host se_host_checker i_chk (.*);

// ### test/serial_eeprom_rw_engine_bench.sv
// self-checking bench: se_host against the eeprom model
// assumes QUARTER 2, POLL_MAX 8 and device straps 3'h5
`timescale 1ns/100ps
module serial_eeprom_rw_engine_bench;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	se_pkg::se_cmd_t cmd_i = '0;
	logic cmd_valid_i = 1'b0;
	logic [7:0] wr_data_i = 8'h00;
	logic wr_valid_i = 1'b0;
	logic protect = 1'b0;
	logic cmd_ready_o, wr_ready_o, rd_valid_o, busy_o, done_o, err_o;
	logic scl_o, sda_o, sda_oe_n_o, sda_low, sda;
	se_pkg::se_rd_t rd_o;
	logic [7:0] shadow [4096];
	logic [7:0] wq [$];
	se_pkg::se_rd_t rq [$];
	logic [11:0] sptr;
	logic [11:0] a;
	int len;
	int n_fail = 0;
	int samples_checked = 0;
	always #2.5 clk_i = ~clk_i;
	assign sda = (sda_oe_n_o | sda_o) & !sda_low;
	se_host #(.QUARTER(2), .POLL_MAX(8)) i_dut (.clk_i(clk_i), .reset_i(reset_i),
		.cmd_i(cmd_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
		.wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
		.rd_o(rd_o), .rd_valid_o(rd_valid_o), .busy_o(busy_o), .done_o(done_o),
		.err_o(err_o), .scl_o(scl_o), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o));
	se_eeprom_model i_mem (.clk_i(clk_i), .scl_i(scl_o), .sda_i(sda), .protect_i(protect),
		.sda_low_o(sda_low));
	always @(posedge clk_i) begin
		if (wr_valid_i && wr_ready_o) void'(wq.pop_front());
		if (rd_valid_o) rq.push_back(rd_o);
	end
	always @(negedge clk_i) begin
		wr_valid_i <= wq.size() > 0;
		wr_data_i <= wq.size() > 0 ? wq[0] : 8'h00;
	end
	task automatic tally_and_finish;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic int clip(input logic [11:0] ad, input int n);
		return n < 32 - ad[4:0] ? n : 32 - ad[4:0];
	endfunction
	task automatic run(input logic [1:0] op, input logic rg, input logic [2:0] st,
		input logic [11:0] ad, input logic [5:0] n, input logic xerr);
		int k;
		@(negedge clk_i);
		cmd_i = '{se_pkg::se_op_t'(op), rg, st, ad, n};
		cmd_valid_i = 1'b1;
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		k = 0;
		while (done_o !== 1'b1 && k < 6000) begin
			@(negedge clk_i);
			k++;
		end
		if (k == 6000) begin
			n_fail++;
			tally_and_finish();
		end
		check(err_o, xerr);
	endtask
	task automatic wr(input logic [11:0] ad, input int n, input logic prot, input logic poll);
		int m;
		logic [7:0] d;
		m = clip(ad, n);
		protect = prot;
		for (int i = 0; i < m; i++) begin
			d = 8'($urandom);
			wq.push_back(d);
			if (!prot) shadow[{ad[11:5], 5'(ad[4:0] + i)}] = d;
		end
		run(2'h0, 1'b0, 3'h5, ad, 6'(n), 1'b0);
		check(wq.size(), 0);
		sptr = {ad[11:5], 5'(ad[4:0] + m)};
		if (poll) run(2'h3, 1'b0, 3'h5, ad, 6'h01, 1'b0);
	endtask
	task automatic rd(input logic [1:0] op, input logic rg, input logic [11:0] ad, input int n);
		rq.delete();
		if (op == 2'h2) sptr = ad;
		run(op, rg, 3'h5, ad, 6'(n), 1'b0);
		check(rq.size(), n);
		foreach (rq[i]) begin
			check(rq[i].data, shadow[sptr]);
			check(rq[i].last, i == n - 1);
			sptr++;
		end
	endtask
	initial begin
		void'($urandom(32'h3BAB));
		foreach (shadow[i]) shadow[i] = 8'hFF;
		repeat (8) @(negedge clk_i);
		reset_i = 1'b0;
		repeat (6) begin
			a = 12'($urandom);
			len = 1 + $urandom % 32;
			wr(a, len, 1'b0, 1'b1);
			rd(2'h2, 1'b0, a, len);
			rd(2'h1, 1'b0, a, 2);
		end
		$display("test random page writes done");
		// page tail clip, top of array wrap
		wr(12'h03F, 32, 1'b0, 1'b1);
		rd(2'h2, 1'b0, 12'hFFF, 3);
		$display("test clip and wrap done");
		// busy device, protect at and after stop
		wr(12'h120, 4, 1'b0, 1'b0);
		run(2'h2, 1'b0, 3'h5, 12'h120, 6'h01, 1'b1);
		run(2'h3, 1'b0, 3'h5, 12'h000, 6'h01, 1'b0);
		wr(12'h120, 4, 1'b1, 1'b0);
		rd(2'h2, 1'b0, 12'h120, 4);
		wr(12'h200, 2, 1'b0, 1'b0);
		protect = 1'b1;
		run(2'h3, 1'b0, 3'h5, 12'h000, 6'h01, 1'b0);
		rd(2'h2, 1'b0, 12'h200, 2);
		$display("test busy and protect done");
		// refusals and region switch
		run(2'h0, 1'b0, 3'h5, 12'h000, 6'h00, 1'b1);
		run(2'h1, 1'b1, 3'h5, 12'h000, 6'h01, 1'b1);
		rd(2'h2, 1'b1, 12'h800, 2);
		run(2'h1, 1'b0, 3'h5, 12'h000, 6'h01, 1'b1);
		rd(2'h1, 1'b1, 12'h000, 1);
		run(2'h2, 1'b0, 3'h2, 12'h000, 6'h01, 1'b1);
		$display("test refusals done");
		tally_and_finish();
	end
endmodule
